// >>> core/gcr_pkg.sv
// Functional notes
// - bits 7:4 select remote mirror per pin
// - bits 3:0 drive pins when local, enabled
// - direction bits 7:4 are drive enables
// - direction bits 3:0 sample enables, reset set
// - pass-any bit passes every long type
// - match bit passes packets equal stored type
// - match value writes ignored while matching
// - yuv10 types pass with bit and 100 mode
// - bit 1 inverts frame valid
// - bit 0 inverts line valid
// - match passes regardless of rate mode
// - match needs stored value long type
// - self-clearing force bit injects count errors
// - entering self test injects errors automatically
// - bits 6:0 hold error count, reset zero
// - bits 7:4 forced error enable, reset zero
// - bit 3 forces self test mode
// - bits 2:1 select self test clock
// - bit 0 enables far self test
// - 0x0f upper read-only, lower writable, zero
package gcr_pkg;
  localparam logic [7:0] ADDR_PIN_VALUE = 8'h0d;
  localparam logic [7:0] ADDR_PIN_DIR   = 8'h0e;
  localparam logic [7:0] ADDR_SPARE_0F  = 8'h0f;
  localparam logic [7:0] ADDR_FILT_CFG  = 8'h10;
  localparam logic [7:0] ADDR_TYPE_MAT  = 8'h11;
  localparam logic [7:0] ADDR_SPARE_12  = 8'h12;
  localparam logic [7:0] ADDR_INJECT    = 8'h13;
  localparam logic [7:0] ADDR_SELFTEST  = 8'h14;

  localparam logic [7:0] RST_PIN_VALUE  = 8'hf0;
  localparam logic [7:0] RST_PIN_DIR    = 8'h0f;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  localparam int BIT_ANY   = 4;
  localparam int BIT_MATCH = 3;
  localparam int BIT_YUV   = 2;
  localparam int BIT_FV    = 1;
  localparam int BIT_LV    = 0;
  localparam int BIT_FORCE = 7;
  localparam int BIT_ENTRY = 3;
  localparam int BIT_FAR   = 0;

  localparam logic [7:0] MASK_0F_WR   = 8'h0f;
  localparam logic [7:0] MASK_TYPE_WR = 8'h3f;
  localparam logic [5:0] DT_YUV_A     = 6'h19;
  localparam logic [5:0] DT_YUV_B     = 6'h1d;
  localparam logic [5:0] DT_YUV_C     = 6'h1f;

  typedef enum logic [1:0] {
    GCR_CLK_EXT   = 2'b00,
    GCR_CLK_50M   = 2'b01,
    GCR_CLK_25M_A = 2'b10,
    GCR_CLK_25M_B = 2'b11
  } gcr_clk_sel_t;

  // long data type when bit 5 or bit 4 set
  function automatic logic gcr_is_long(input logic [5:0] dt);
    return dt[5] | dt[4];
  endfunction : gcr_is_long
endpackage : gcr_pkg

// >>> core/gcr_filt_if.sv
// filter settings carried from the register bank to the packet filter
interface gcr_filt_if;
  import gcr_pkg::*;
  logic       pass_any_long_type;
  logic       type_match_en;
  logic       pass_yuv10_types;
  logic [5:0] type_match_value;
  modport src (output pass_any_long_type, output type_match_en, output pass_yuv10_types, output type_match_value);
  modport dst (input pass_any_long_type, input type_match_en, input pass_yuv10_types, input type_match_value);
endinterface : gcr_filt_if

// >>> core/gcr_type_filter.sv
// packet data-type pass decision, registered
module gcr_type_filter
  import gcr_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  gcr_filt_if.dst    cfg,
  input  wire logic  i_rate_100_mode,
  input  wire logic  i_pkt_valid,
  input  wire logic [5:0] i_pkt_type,
  output logic       o_pkt_pass
);
  logic pass_d;
  logic pass_q;

  // any of the three pass routes admits the packet
  always_comb begin
    pass_d = 1'b0;
    if (i_pkt_valid) begin
      if (cfg.pass_any_long_type && gcr_is_long(i_pkt_type))
        pass_d = 1'b1;
      if (cfg.type_match_en && gcr_is_long(cfg.type_match_value) &&
          (i_pkt_type == cfg.type_match_value))
        pass_d = 1'b1;
      if (cfg.pass_yuv10_types && i_rate_100_mode &&
          (i_pkt_type == DT_YUV_A || i_pkt_type == DT_YUV_B || i_pkt_type == DT_YUV_C))
        pass_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      pass_q <= 1'b0;
    else
      pass_q <= pass_d;
  end

  assign o_pkt_pass = pass_q;
endmodule : gcr_type_filter

// >>> core/gcr_err_inject.sv
// emits one parity-error pulse per clock cycle until the count runs out
module gcr_err_inject
  import gcr_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_err_pulse,
  output logic                  o_busy
);
  logic [CNT_W-1:0] left_d;
  logic [CNT_W-1:0] left_q;
  logic             pulse_d;
  logic             pulse_q;

  // a new start reloads; a zero count injects nothing
  always_comb begin
    left_d  = left_q;
    pulse_d = 1'b0;
    if (i_start)
      left_d = i_count;
    else if (left_q != '0) begin
      left_d  = left_q - 1'b1;
      pulse_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      left_q  <= '0;
      pulse_q <= 1'b0;
    end else begin
      left_q  <= left_d;
      pulse_q <= pulse_d;
    end
  end

  assign o_err_pulse = pulse_q;
  assign o_busy      = (left_q != '0);
endmodule : gcr_err_inject

// >>> core/gcr_regs.sv
// configuration bank for pins, packet filter and self test
module gcr_regs
  import gcr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // byte register port from the control-channel target
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // pins
  input  wire logic [3:0] i_remote_pin_data,
  input  wire logic [3:0] i_pin_in,
  output logic      [3:0] o_pin_out,
  output logic      [3:0] o_pin_oe_n,
  output logic      [3:0] o_pin_sampled,
  // video path
  input  wire logic       i_rate_100_mode,
  input  wire logic       i_frame_valid,
  input  wire logic       i_line_valid,
  input  wire logic       i_pkt_valid,
  input  wire logic [5:0] i_pkt_type,
  output logic            o_frame_valid,
  output logic            o_line_valid,
  output logic            o_pkt_pass,
  // self test
  output logic            o_parity_err_inject,
  output logic            o_self_test_mode,
  output logic      [1:0] o_self_test_clock_sel,
  output logic            o_far_self_test_en,
  output logic      [3:0] o_forced_error_enable
);
  logic [7:0] pin_value_d, pin_value_q;
  logic [7:0] pin_dir_d,   pin_dir_q;
  logic [3:0] spare0f_d,   spare0f_q;
  logic [7:0] filt_d,      filt_q;
  logic [5:0] match_d,     match_q;
  logic [6:0] count_d,     count_q;
  logic [7:0] stest_d,     stest_q;
  logic       entry_prev_q;
  logic [7:0] rdata_d,     rdata_q;
  logic [3:0] pin_out_d,   pin_out_q;
  logic [3:0] samp_d,      samp_q;
  logic       fv_d, fv_q, lv_d, lv_q;
  logic       inj_start;
  logic       inj_busy;

  gcr_filt_if filt_bus ();

  // register writes; force bit is a one-cycle strobe, never stored
  always_comb begin
    pin_value_d = pin_value_q;
    pin_dir_d   = pin_dir_q;
    spare0f_d   = spare0f_q;
    filt_d      = filt_q;
    match_d     = match_q;
    count_d     = count_q;
    stest_d     = stest_q;
    if (i_wr_en) begin
      case (i_addr)
        ADDR_PIN_VALUE: pin_value_d = i_wdata;
        ADDR_PIN_DIR:   pin_dir_d   = i_wdata;
        ADDR_SPARE_0F:  spare0f_d   = i_wdata[3:0];
        ADDR_FILT_CFG:  filt_d      = i_wdata;
        // match value frozen while matching is live
        ADDR_TYPE_MAT: begin
          if (!filt_q[BIT_MATCH])
            match_d = i_wdata[5:0];
        end
        ADDR_INJECT:    count_d     = i_wdata[6:0];
        ADDR_SELFTEST:  stest_d     = i_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_value_q <= RST_PIN_VALUE;
      pin_dir_q   <= RST_PIN_DIR;
      spare0f_q   <= RST_ZERO[3:0];
      filt_q      <= RST_ZERO;
      match_q     <= RST_ZERO[5:0];
      count_q     <= RST_ZERO[6:0];
      stest_q     <= RST_ZERO;
    end else begin
      pin_value_q <= pin_value_d;
      pin_dir_q   <= pin_dir_d;
      spare0f_q   <= spare0f_d;
      filt_q      <= filt_d;
      match_q     <= match_d;
      count_q     <= count_d;
      stest_q     <= stest_d;
    end
  end

  // injection starts on a force write, or on the rise into self test
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      entry_prev_q <= 1'b0;
    else
      entry_prev_q <= stest_q[BIT_ENTRY];
  end

  assign inj_start = (i_wr_en && i_addr == ADDR_INJECT && i_wdata[BIT_FORCE])
                   | (stest_q[BIT_ENTRY] && !entry_prev_q);

  gcr_err_inject #(
    .CNT_W (7)
  ) u_inject (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_start     (inj_start),
    .i_count     (inj_start && i_wr_en && i_addr == ADDR_INJECT ? i_wdata[6:0] : count_q),
    .o_err_pulse (o_parity_err_inject),
    .o_busy      (inj_busy)
  );

  // readback; force bit reads as busy so software sees it clear itself
  always_comb begin
    case (i_addr)
      ADDR_PIN_VALUE: rdata_d = pin_value_q;
      ADDR_PIN_DIR:   rdata_d = pin_dir_q;
      ADDR_SPARE_0F:  rdata_d = {4'h0, spare0f_q};
      ADDR_FILT_CFG:  rdata_d = filt_q;
      ADDR_TYPE_MAT:  rdata_d = {2'h0, match_q};
      ADDR_SPARE_12:  rdata_d = RST_ZERO;
      ADDR_INJECT:    rdata_d = {inj_busy, count_q};
      ADDR_SELFTEST:  rdata_d = stest_q;
      default:        rdata_d = RST_ZERO;
    endcase
  end

  // pin drive, sampling and sync polarity
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_out_d[i] = pin_value_q[4+i] ? i_remote_pin_data[i] : pin_value_q[i];
      samp_d[i]    = pin_dir_q[i] ? i_pin_in[i] : samp_q[i];
    end
    fv_d = i_frame_valid ^ filt_q[BIT_FV];
    lv_d = i_line_valid ^ filt_q[BIT_LV];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q   <= RST_ZERO;
      pin_out_q <= RST_ZERO[3:0];
      samp_q    <= RST_ZERO[3:0];
      fv_q      <= 1'b0;
      lv_q      <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      pin_out_q <= pin_out_d;
      samp_q    <= samp_d;
      fv_q      <= fv_d;
      lv_q      <= lv_d;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_pin_out     = pin_out_q;
  assign o_pin_oe_n    = ~pin_dir_q[7:4];
  assign o_pin_sampled = samp_q;
  assign o_frame_valid = fv_q;
  assign o_line_valid  = lv_q;

  // filter settings to the packet filter
  assign filt_bus.pass_any_long_type = filt_q[BIT_ANY];
  assign filt_bus.type_match_en      = filt_q[BIT_MATCH];
  assign filt_bus.pass_yuv10_types   = filt_q[BIT_YUV];
  assign filt_bus.type_match_value   = match_q;

  gcr_type_filter u_filter (
    .i_clk           (i_clk),
    .i_resetn        (i_resetn),
    .cfg             (filt_bus),
    .i_rate_100_mode (i_rate_100_mode),
    .i_pkt_valid     (i_pkt_valid),
    .i_pkt_type      (i_pkt_type),
    .o_pkt_pass      (o_pkt_pass)
  );

  // self test controls straight from the register
  assign o_self_test_mode      = stest_q[BIT_ENTRY];
  assign o_self_test_clock_sel = stest_q[2:1];
  assign o_far_self_test_en    = stest_q[BIT_FAR];
  assign o_forced_error_enable = stest_q[7:4];
endmodule : gcr_regs

// >>> testbench/gcr_regs_properties.sv
module gcr_regs_properties
  import gcr_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] i_remote_pin_data,
  input wire logic [3:0] i_pin_in,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe_n,
  input wire logic [3:0] o_pin_sampled,
  input wire logic       i_rate_100_mode,
  input wire logic       i_frame_valid,
  input wire logic       i_line_valid,
  input wire logic       i_pkt_valid,
  input wire logic [5:0] i_pkt_type,
  input wire logic       o_frame_valid,
  input wire logic       o_line_valid,
  input wire logic       o_pkt_pass,
  input wire logic       o_parity_err_inject,
  input wire logic       o_self_test_mode,
  input wire logic [1:0] o_self_test_clock_sel,
  input wire logic       o_far_self_test_en,
  input wire logic [3:0] o_forced_error_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pv_q, dir_q, cfg_q, mv_q;
  logic [6:0] cnt_q, seen_q;
  logic       start, pass_w, t19;
  // start of a burst: force bit, or a rise of the self-test entry bit
  assign start = i_wr_en & ((i_addr == ADDR_INJECT & i_wdata[7])
                 | (i_addr == ADDR_SELFTEST & i_wdata[3] & ~o_self_test_mode));
  assign t19 = (i_pkt_type == 6'h19) | (i_pkt_type == 6'h1d) | (i_pkt_type == 6'h1f);
  assign pass_w = i_pkt_valid & ((cfg_q[4] & (i_pkt_type[5] | i_pkt_type[4]))
                  | (cfg_q[3] & (mv_q[5] | mv_q[4]) & (i_pkt_type == mv_q[5:0]))
                  | (cfg_q[2] & i_rate_100_mode & t19));
  // shadow of the pin, filter, match and count registers, rebuilt from the write port; seen_q counts the observed error pulses
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pv_q   <= 8'hf0;
      dir_q  <= 8'h0f;
      cfg_q  <= 8'h00;
      mv_q   <= 8'h00;
      cnt_q  <= 7'h00;
      seen_q <= 7'h00;
    end else begin
      if (i_wr_en & i_addr == ADDR_PIN_VALUE) pv_q <= i_wdata;
      if (i_wr_en & i_addr == ADDR_PIN_DIR) dir_q <= i_wdata;
      if (i_wr_en & i_addr == ADDR_FILT_CFG) cfg_q <= i_wdata;
      if (i_wr_en & i_addr == ADDR_TYPE_MAT & ~cfg_q[3]) mv_q <= i_wdata;
      if (i_wr_en & i_addr == ADDR_INJECT) cnt_q <= i_wdata[6:0];
      seen_q <= start ? 7'h00 : seen_q + 7'(o_parity_err_inject);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_PIN_OUT: assert property (o_pin_out ==
    $past((pv_q[7:4] & i_remote_pin_data) | (~pv_q[7:4] & pv_q[3:0])))
    else $error("pin drive value wrong");
  AST_PIN_OE: assert property (i_wr_en && i_addr == ADDR_PIN_DIR |=> o_pin_oe_n == ~$past(i_wdata[7:4]))
    else $error("pin drive enable wrong");
  AST_SAMPLE: assert property (o_pin_sampled ==
    $past((dir_q[3:0] & i_pin_in) | (~dir_q[3:0] & o_pin_sampled)))
    else $error("pin sample wrong");
  AST_FV: assert property (o_frame_valid == $past(i_frame_valid ^ cfg_q[1]))
    else $error("frame valid polarity wrong");
  AST_LV: assert property (o_line_valid == $past(i_line_valid ^ cfg_q[0]))
    else $error("line valid polarity wrong");
  AST_PASS: assert property (o_pkt_pass == $past(pass_w))
    else $error("packet pass decision wrong");
  AST_INJ: assert property ($fell(o_parity_err_inject) |-> seen_q == cnt_q)
    else $error("injected error count wrong");
  AST_ST: assert property (i_wr_en && i_addr == ADDR_SELFTEST |=>
    {o_forced_error_enable, o_self_test_mode, o_self_test_clock_sel, o_far_self_test_en} == $past(i_wdata))
    else $error("self test outputs wrong");
  AST_SPARE: assert property (i_addr == ADDR_SPARE_0F |=> o_rdata[7:4] == 4'h0)
    else $error("read-only nibble not zero");
  cover property ($fell(o_parity_err_inject));
  cover property (o_pkt_pass);
  cover property ($rose(o_self_test_mode));
endmodule : gcr_regs_properties
bind gcr_regs gcr_regs_properties u_props (.*);

// >>> testbench/gcr_ctrl_model.sv
// register-port controller; data lines show junk once released
module gcr_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // an edge passes first, so back-to-back writes never retoggle the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_wdata = ~d;
  endtask : wr
  // answer is registered: taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask : rd
endmodule : gcr_ctrl_model

// >>> testbench/test_gcr_regs.sv
module test_gcr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import gcr_pkg::*;
  logic       i_clk, i_resetn, i_wr_en, i_rate_100_mode, i_frame_valid, i_line_valid, i_pkt_valid;
  logic [7:0] i_addr, i_wdata, o_rdata, rv;
  logic [3:0] i_remote_pin_data, i_pin_in, o_pin_out, o_pin_oe_n, o_pin_sampled, o_forced_error_enable;
  logic [5:0] i_pkt_type;
  logic       o_frame_valid, o_line_valid, o_pkt_pass, o_parity_err_inject, o_self_test_mode, o_far_self_test_en;
  logic [1:0] o_self_test_clock_sel;
  int         miscompares, cmp_count, n;
  logic [7:0] st_bits;
  localparam logic [7:0] RST [8] = '{8'hf0, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // self test outputs packed in register bit order
  assign st_bits = {o_forced_error_enable, o_self_test_mode, o_self_test_clock_sel, o_far_self_test_en};
  gcr_regs dut (.*);
  gcr_ctrl_model m (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr_en(i_wr_en), .o_addr(i_addr), .o_wdata(i_wdata));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    m.rd(a, rv);
    chk(rv, e);
  endtask : rdc
  // one packet; the pass flag is registered on the taking edge
  task automatic pkt(input logic [5:0] t, input logic e);
    i_pkt_valid = 1'b1;
    i_pkt_type  = t;
    cyc(1);
    chk(8'(o_pkt_pass), 8'(e));
    // idle cycle keeps the next valid rise in a time step of its own
    i_pkt_valid = 1'b0;
    cyc(1);
  endtask : pkt
  task automatic pulses(input int e);
    n = 0;
    repeat (12) begin
      cyc(1);
      if (o_parity_err_inject === 1'b1) n++;
    end
    chk(8'(n), 8'(e));
  endtask : pulses
  initial begin
    #200us;
    miscompares++;
    print_verdict();
  end
  initial begin
    {i_resetn, i_rate_100_mode, i_frame_valid, i_line_valid, i_pkt_valid} = 5'h00;
    {i_remote_pin_data, i_pin_in, i_pkt_type} = 14'h0000;
    cyc(20);
    i_resetn = 1'b1;
    chk({4'h0, o_pin_oe_n}, 8'h0f);
    for (int a = 0; a < 8; a++) rdc(8'(a + 13), RST[a]);
    rdc(8'h20, 8'h00);
    m.wr(ADDR_SPARE_0F, 8'hff);
    rdc(ADDR_SPARE_0F, 8'h0f);
    i_remote_pin_data = 4'ha;
    m.wr(ADDR_PIN_VALUE, 8'h35);
    m.wr(ADDR_PIN_DIR, 8'hf5);
    i_pin_in = 4'hc;
    cyc(2);
    chk({4'h0, o_pin_out}, 8'h06);
    chk({4'h0, o_pin_oe_n}, 8'h00);
    chk({4'h0, o_pin_sampled}, 8'h04);
    i_frame_valid = 1'b1;
    m.wr(ADDR_FILT_CFG, 8'h03);
    cyc(1);
    chk({6'h00, o_frame_valid, o_line_valid}, 8'h01);
    m.wr(ADDR_TYPE_MAT, 8'h2a);
    m.wr(ADDR_FILT_CFG, 8'h08);
    m.wr(ADDR_TYPE_MAT, 8'h15);
    rdc(ADDR_TYPE_MAT, 8'h2a);
    pkt(6'h2a, 1'b1);
    pkt(6'h15, 1'b0);
    m.wr(ADDR_FILT_CFG, 8'h04);
    i_rate_100_mode = 1'b1;
    pkt(6'h19, 1'b1);
    pkt(6'h1d, 1'b1);
    pkt(6'h1f, 1'b1);
    pkt(6'h1e, 1'b0);
    i_rate_100_mode = 1'b0;
    pkt(6'h19, 1'b0);
    m.wr(ADDR_FILT_CFG, 8'h10);
    pkt(6'h20, 1'b1);
    pkt(6'h0f, 1'b0);
    m.wr(ADDR_FILT_CFG, 8'h00);
    m.wr(ADDR_TYPE_MAT, 8'h05);
    m.wr(ADDR_FILT_CFG, 8'h08);
    pkt(6'h05, 1'b0);
    m.wr(ADDR_INJECT, 8'h83);
    pulses(3);
    rdc(ADDR_INJECT, 8'h03);
    m.wr(ADDR_INJECT, 8'h05);
    pulses(0);
    rdc(ADDR_INJECT, 8'h05);
    m.wr(ADDR_SELFTEST, 8'hfd);
    chk(st_bits, 8'hfd);
    pulses(5);
    for (int s = 0; s < 4; s++) begin
      m.wr(ADDR_SELFTEST, 8'(s * 2));
      chk({6'h00, o_self_test_clock_sel}, 8'(s));
    end
    print_verdict();
  end
endmodule : test_gcr_regs
